/* uivc_pkg.sv */
package uivc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] UIVC_INT_STATUS_ADDR  = 16'h4004; // interrupt_status_zero
  localparam logic [15:0] UIVC_FIFO_STATUS_ADDR = 16'h402C; // bulk_tx_fifo_status
  localparam logic [15:0] UIVC_XCVR_CTRL_ADDR   = 16'h4040; // usb_transceiver_control
  localparam logic [15:0] UIVC_USB_STATUS_ADDR  = 16'h4032; // USB status holding mailbox valid
  localparam logic [15:0] UIVC_INT_MASK_ADDR    = 16'h4002; // Interrupt mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UIVC_MBOX_VALID_BIT  = 0; // USB status: mailbox valid (plain RW)
  localparam int UIVC_USB_NAK_BIT     = 1; // USB status: NAK sent (W1C)
  localparam int UIVC_MBOX_SENT_BIT   = 2; // Int status: mailbox sent
  localparam int UIVC_BULK_IRQ_BIT    = 4; // Int status: bulk endpoint status
  localparam int UIVC_FIFO_VALID_BIT  = 5; // FIFO status: transmit valid
  localparam int UIVC_TOGGLE_BIT      = 7; // FIFO status: current data toggle
  localparam int UIVC_RX_ENABLE_BIT   = 6; // Transceiver: receiver enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UIVC_XCVR_RESET = 8'h40;
  localparam logic [7:0] UIVC_MASK_RESET = 8'h00;

  // Token answers
  typedef enum logic [1:0] {UIVC_ANS_NONE, UIVC_ANS_NAK, UIVC_ANS_DATA, UIVC_ANS_ZLP} uivc_ans_t;

endpackage

/* uivc_w1c_bit.sv */
`timescale 1ns/1ns
// Sticky status bit: hardware set wins over write-one clear
module uivc_w1c_bit
  import uivc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Controls
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      q_o
);

  // Set has priority over the clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end

  chk_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) set_i |=> q_o)
    else $error("sticky bit lost a set");

endmodule

/* uivc_token_fsm.sv */
`timescale 1ns/1ns
// Bulk IN token answer decision and data toggle
module uivc_token_fsm
  import uivc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  // Token side
  input  wire logic      in_token_i,
  input  wire logic      ack_i,
  input  wire logic      fifo_valid_i,
  input  wire logic      valid_late_i,
  input  wire logic      zlp_defect_en_i,
  // Results
  output uivc_ans_t      answer_o,
  output logic           sent_o,
  output logic           toggle_o
);

  typedef enum {UIVC_IDLE, UIVC_WAIT_ACK} uivc_state_t;
  uivc_state_t state;
  uivc_ans_t   next_answer;

  // Decide answer from the valid flag at token time
  always_comb
  begin
    next_answer = UIVC_ANS_NONE;
    if (in_token_i && state == UIVC_IDLE)
    begin
      if (fifo_valid_i && !valid_late_i)
        next_answer = UIVC_ANS_DATA;
      else if (fifo_valid_i && zlp_defect_en_i)
        next_answer = UIVC_ANS_ZLP; // Late set turns NAK into empty data [R07]
      else
        next_answer = UIVC_ANS_NAK; // [R06]
    end
  end

  // Answer register and ack wait
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= UIVC_IDLE;
      answer_o <= UIVC_ANS_NONE;
      sent_o   <= 1'b0;
      toggle_o <= 1'b0;
    end
    else
    begin
      answer_o <= next_answer;
      sent_o   <= 1'b0;
      unique case (state)
        UIVC_IDLE:
          if (next_answer == UIVC_ANS_DATA || next_answer == UIVC_ANS_ZLP)
            state <= UIVC_WAIT_ACK;
        UIVC_WAIT_ACK:
          if (ack_i || in_token_i)
          begin
            state <= UIVC_IDLE;
            if (ack_i)
            begin
              sent_o   <= 1'b1;
              toggle_o <= ~toggle_o; // Alternate on acknowledged data [R16]
            end
          end
      endcase
    end
  end

  chk_nak_on_empty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_token_i && state == UIVC_IDLE && !fifo_valid_i) |=> answer_o == UIVC_ANS_NAK) // [R06]
    else $error("empty endpoint not NAKed");

  chk_toggle_flip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == UIVC_WAIT_ACK && ack_i) |=> toggle_o != $past(toggle_o)) // [R16]
    else $error("toggle did not alternate");

endmodule

/* uivc_top.sv */
`timescale 1ns/1ns
// Function
// R01: Mailbox valid is plain RW, others W1C
// R02: Device clears mailbox valid after delivery
// R03: Firmware uses read-modify-write on USB status
// R04: Firmware writes zero after mailbox-sent interrupt
// R05: Transmit valid is bit 5 at 402C
// R06: Token with valid clear gets NAK
// R07: Late valid set may yield zero-length packet
// R08: Bit 6 at 4040 enables receiver
// R09: Bulk status bit 4 at 4004, W1C
// R10: Firmware disables receiver, waits, sets valid
// R11: Disable-to-clear sequence under six microseconds
// R12: Valid set and status clear within 5us
// R13: Without valid, bulk status only on NAK
// R14: Fast firmware polls status then sets valid
// R15: Valid bits mark written data ready
// R16: Data toggle alternates on acknowledged transfers
module uivc_top
  import uivc_pkg::*;
#(
  parameter int LATE_WINDOW = 2 // Cycles before the token in which a valid set collides
)
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // Register port
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // Link events from the serial engine
  input  wire logic        BULK_IN_TOKEN_I,
  input  wire logic        MBOX_IN_TOKEN_I,
  input  wire logic        HOST_ACK_I,
  input  wire logic        ZLP_DEFECT_EN_I,
  // Link answers
  output logic      [1:0]  BULK_ANSWER_O,
  output logic             MBOX_DATA_O,
  output logic             DATA_TOGGLE_O,
  output logic             RX_ENABLE_O,
  // Interrupt
  output logic             IRQ_O
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Release reset through two flops
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_usb;
  logic wr_int;
  logic wr_fifo;
  logic wr_xcvr;
  logic wr_mask;

  assign wr_usb  = WR_I && ADDR_I == UIVC_USB_STATUS_ADDR;
  assign wr_int  = WR_I && ADDR_I == UIVC_INT_STATUS_ADDR;
  assign wr_fifo = WR_I && ADDR_I == UIVC_FIFO_STATUS_ADDR;
  assign wr_xcvr = WR_I && ADDR_I == UIVC_XCVR_CTRL_ADDR;
  assign wr_mask = WR_I && ADDR_I == UIVC_INT_MASK_ADDR;

  // ----------------------------------------------------------------
  // Control and valid flags
  // ----------------------------------------------------------------
  logic [7:0] xcvr_ctrl;
  logic [7:0] int_mask;
  logic       mbox_valid;
  logic       fifo_valid;
  logic [7:0] since_set;
  logic       rx_en;
  logic       bulk_tok;
  logic       mbox_tok;
  uivc_ans_t  answer;
  logic       bulk_sent;
  logic       toggle;
  logic       usb_nak;
  logic       bulk_irq;
  logic       mbox_sent_irq;
  logic       bulk_nak_ev;

  assign rx_en    = xcvr_ctrl[UIVC_RX_ENABLE_BIT];
  assign bulk_tok = BULK_IN_TOKEN_I && rx_en; // Ignore tokens while receiver off [R08]
  assign mbox_tok = MBOX_IN_TOKEN_I && rx_en;

  // Transceiver control and interrupt mask
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcvr_ctrl <= UIVC_XCVR_RESET;
      int_mask  <= UIVC_MASK_RESET;
    end
    else
    begin
      if (wr_xcvr)
        xcvr_ctrl <= WDATA_I; // [R08]
      if (wr_mask)
        int_mask <= WDATA_I;
    end
  end

  // Mailbox valid: plain RW bit, cleared by delivery
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      mbox_valid <= 1'b0;
    else if (wr_usb)
      mbox_valid <= WDATA_I[UIVC_MBOX_VALID_BIT]; // [R01] [R15]
    else if (mbox_tok && mbox_valid)
      mbox_valid <= 1'b0; // Delivered to host [R02]
  end

  // Transmit FIFO valid: set by firmware, cleared on acknowledged data
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_valid <= 1'b0;
      since_set  <= 8'hFF;
    end
    else
    begin
      if (wr_fifo)
        fifo_valid <= WDATA_I[UIVC_FIFO_VALID_BIT]; // [R05] [R15]
      else if (bulk_sent)
        fifo_valid <= 1'b0;
      if (wr_fifo && WDATA_I[UIVC_FIFO_VALID_BIT] && !fifo_valid)
        since_set <= 8'h00;
      else if (since_set != 8'hFF)
        since_set <= since_set + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Token answer engine
  // ----------------------------------------------------------------
  uivc_token_fsm u_fsm (
    .clk_i           (SYS_CLK_I),
    .rst_n_i         (rst_n),
    .in_token_i      (bulk_tok),
    .ack_i           (HOST_ACK_I),
    .fifo_valid_i    (fifo_valid),
    .valid_late_i    (since_set < 8'(LATE_WINDOW)), // [R07]
    .zlp_defect_en_i (ZLP_DEFECT_EN_I),
    .answer_o        (answer),
    .sent_o          (bulk_sent),
    .toggle_o        (toggle)
  );

  // NAK sent on bulk endpoint
  assign bulk_nak_ev = answer == UIVC_ANS_NAK;

  // ----------------------------------------------------------------
  // Sticky status bits
  // ----------------------------------------------------------------
  // Bulk status set by a NAK or by acknowledged data only [R13]
  uivc_w1c_bit u_bulk_irq (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (rst_n),
    .set_i   (bulk_nak_ev || bulk_sent),
    .clr_i   (wr_int && WDATA_I[UIVC_BULK_IRQ_BIT]), // [R09]
    .q_o     (bulk_irq)
  );

  // Mailbox delivery event
  uivc_w1c_bit u_mbox_irq (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (rst_n),
    .set_i   (mbox_tok && mbox_valid),
    .clr_i   (wr_int && WDATA_I[UIVC_MBOX_SENT_BIT]),
    .q_o     (mbox_sent_irq)
  );

  // NAK flag in USB status is W1C [R01]
  uivc_w1c_bit u_usb_nak (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (rst_n),
    .set_i   (bulk_nak_ev),
    .clr_i   (wr_usb && WDATA_I[UIVC_USB_NAK_BIT]),
    .q_o     (usb_nak)
  );

  // ----------------------------------------------------------------
  // Read data, link outputs, interrupt
  // ----------------------------------------------------------------
  logic [7:0] int_status;
  logic [7:0] next_rdata;

  always_comb
  begin
    int_status = 8'h00;
    int_status[UIVC_BULK_IRQ_BIT]  = bulk_irq;
    int_status[UIVC_MBOX_SENT_BIT] = mbox_sent_irq;
    next_rdata = 8'h00;
    unique case (ADDR_I)
      UIVC_INT_STATUS_ADDR:  next_rdata = int_status;
      UIVC_INT_MASK_ADDR:    next_rdata = int_mask;
      UIVC_XCVR_CTRL_ADDR:   next_rdata = xcvr_ctrl;
      UIVC_FIFO_STATUS_ADDR:
      begin
        next_rdata[UIVC_FIFO_VALID_BIT] = fifo_valid;
        next_rdata[UIVC_TOGGLE_BIT]     = toggle;
      end
      UIVC_USB_STATUS_ADDR:
      begin
        next_rdata[UIVC_MBOX_VALID_BIT] = mbox_valid;
        next_rdata[UIVC_USB_NAK_BIT]    = usb_nak;
      end
      default:               next_rdata = 8'h00;
    endcase
  end

  // Registered outputs
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      RDATA_O       <= 8'h00;
      BULK_ANSWER_O <= 2'h0;
      MBOX_DATA_O   <= 1'b0;
      DATA_TOGGLE_O <= 1'b0;
      RX_ENABLE_O   <= 1'b0;
      IRQ_O         <= 1'b0;
    end
    else
    begin
      RDATA_O       <= RD_I ? next_rdata : 8'h00;
      BULK_ANSWER_O <= answer;
      MBOX_DATA_O   <= mbox_tok && mbox_valid;
      DATA_TOGGLE_O <= toggle;
      RX_ENABLE_O   <= rx_en;
      IRQ_O         <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mbox_clear: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R02]
    (mbox_tok && mbox_valid && !wr_usb) |=> !mbox_valid)
    else $error("mailbox valid not cleared on delivery");

  chk_mbox_plain_rw: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R01]
    wr_usb |=> mbox_valid == $past(WDATA_I[UIVC_MBOX_VALID_BIT]))
    else $error("mailbox valid not plain write");

  chk_fifo_valid_wr: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R05]
    wr_fifo |=> fifo_valid == $past(WDATA_I[UIVC_FIFO_VALID_BIT]))
    else $error("transmit valid write lost");

  chk_rx_gate: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R08]
    (!rx_en && !$past(BULK_IN_TOKEN_I && rx_en)) |=> answer == UIVC_ANS_NONE)
    else $error("answer while receiver disabled");

  chk_bulk_w1c: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R09]
    (wr_int && WDATA_I[UIVC_BULK_IRQ_BIT] && !bulk_nak_ev && !bulk_sent) |=> !bulk_irq)
    else $error("bulk status not cleared");

  chk_bulk_only_nak: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R13]
    (!bulk_irq && !bulk_nak_ev && !bulk_sent) |=> !bulk_irq)
    else $error("bulk status set without cause");

  chk_irq_level: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    |(int_status & int_mask) |=> IRQ_O)
    else $error("interrupt not raised");

  chk_read_timing: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // [R15]
    (RD_I && ADDR_I == UIVC_FIFO_STATUS_ADDR) |=> RDATA_O[UIVC_FIFO_VALID_BIT] == $past(fifo_valid))
    else $error("read data wrong");

endmodule

/* uivc_host_model.sv */
`timescale 1ns/1ns
// Host side of the link: issues IN tokens and acknowledges data packets
module uivc_host_model
  import uivc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Device answers
  input  wire logic [1:0] answer_i,
  input  wire logic       mbox_data_i,
  // Tokens and handshake
  output logic            bulk_token_o,
  output logic            mbox_token_o,
  output logic            ack_o
);
  int ack_delay = 1; // Cycles before ACK; raise it to act as a slow host
  int mbox_seen = 0; // Mailbox packets seen on the link

  // ----------------------------------------------------------------
  // Link idle state
  // ----------------------------------------------------------------
  initial
  begin
    bulk_token_o = 1'b0;
    mbox_token_o = 1'b0;
    ack_o        = 1'b0;
  end

  // Count mailbox deliveries
  always @(posedge clk_i)
    if (mbox_data_i === 1'b1)
      mbox_seen <= mbox_seen + 1;

  // Bulk IN token; ACK any data packet, empty ones too
  task automatic bulk_in(output logic [1:0] ans);
    int i;
    ans = 2'h0;
    @(posedge clk_i) bulk_token_o <= 1'b1;
    @(posedge clk_i) bulk_token_o <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      #1;
      if (answer_i !== 2'h0)
        ans = answer_i;
    end
    if (ans == UIVC_ANS_DATA || ans == UIVC_ANS_ZLP)
    begin
      repeat (ack_delay) @(posedge clk_i);
      ack_o <= 1'b1;
      @(posedge clk_i) ack_o <= 1'b0;
    end
  endtask

  // Mailbox IN token
  task automatic mbox_in;
    @(posedge clk_i) mbox_token_o <= 1'b1;
    @(posedge clk_i) mbox_token_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* uivc_top_test.sv */
`timescale 1ns/1ns
// Register and link level test of the transmit valid control
module uivc_top_test
  import uivc_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic        zlp_en;
  logic [7:0]  rdata;
  logic        bulk_tok;
  logic        mbox_tok;
  logic        host_ack;
  logic [1:0]  answer;
  logic        mbox_data;
  logic        toggle;
  logic        rx_en;
  logic        irq;
  logic [1:0]  ans;
  int          mismatches = 0;
  int          tests_run = 0;

  // Device and host model
  uivc_top #(.LATE_WINDOW(2)) i_uivc_top (
    .SYS_CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_en), .RD_I(rd_en),
    .RDATA_O(rdata), .BULK_IN_TOKEN_I(bulk_tok), .MBOX_IN_TOKEN_I(mbox_tok), .HOST_ACK_I(host_ack),
    .ZLP_DEFECT_EN_I(zlp_en), .BULK_ANSWER_O(answer), .MBOX_DATA_O(mbox_data),
    .DATA_TOGGLE_O(toggle), .RX_ENABLE_O(rx_en), .IRQ_O(irq));
  uivc_host_model i_uivc_host_model (
    .clk_i(clk), .answer_i(answer), .mbox_data_i(mbox_data),
    .bulk_token_o(bulk_tok), .mbox_token_o(mbox_tok), .ack_o(host_ack));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and compare
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk) wr_en <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk) rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog cuts a hung run short
  initial
  begin
    #300000;
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    zlp_en = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values and an unmapped address
    rchk(UIVC_XCVR_CTRL_ADDR, UIVC_XCVR_RESET, "xcvr_reset");
    rchk(UIVC_INT_MASK_ADDR, UIVC_MASK_RESET, "mask_reset");
    rchk(UIVC_FIFO_STATUS_ADDR, 8'h00, "fifo_reset");
    wr(16'h4010, 8'hFF);
    rchk(16'h4010, 8'h00, "unmapped");
    chk("rx_enable", 8'h01, {7'h00, rx_en});
    $display("test reset done");
    // Token with valid clear: NAK, status, masked interrupt
    wr(UIVC_INT_MASK_ADDR, 8'h10);
    i_uivc_host_model.bulk_in(ans);
    chk("nak_answer", {6'h00, UIVC_ANS_NAK}, {6'h00, ans});
    rchk(UIVC_INT_STATUS_ADDR, 8'h10, "nak_status");
    chk("irq_on", 8'h01, {7'h00, irq});
    wr(UIVC_INT_MASK_ADDR, 8'h00);
    rchk(UIVC_INT_STATUS_ADDR, 8'h10, "status_kept");
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    rchk(UIVC_INT_STATUS_ADDR, 8'h00, "status_w1c");
    $display("test nak done");
    // Valid data, prompt ACK, toggle flips
    wr(UIVC_FIFO_STATUS_ADDR, 8'h20);
    rchk(UIVC_FIFO_STATUS_ADDR, 8'h20, "valid_set");
    i_uivc_host_model.bulk_in(ans);
    chk("data_answer", {6'h00, UIVC_ANS_DATA}, {6'h00, ans});
    repeat (4) @(posedge clk);
    rchk(UIVC_FIFO_STATUS_ADDR, 8'h80, "toggle_after_ack");
    chk("toggle_pin", 8'h01, {7'h00, toggle});
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    $display("test data done");
    // Receiver off, then the guarded valid sequence
    wr(UIVC_XCVR_CTRL_ADDR, 8'h00);
    i_uivc_host_model.bulk_in(ans);
    chk("no_answer", {6'h00, UIVC_ANS_NONE}, {6'h00, ans});
    chk("rx_disabled", 8'h00, {7'h00, rx_en});
    rchk(UIVC_INT_STATUS_ADDR, 8'h00, "no_status_rx_off");
    repeat (100) @(posedge clk);
    wr(UIVC_FIFO_STATUS_ADDR, 8'h20);
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    wr(UIVC_XCVR_CTRL_ADDR, 8'h40);
    i_uivc_host_model.ack_delay = 6;
    i_uivc_host_model.bulk_in(ans);
    chk("data_after_fix", {6'h00, UIVC_ANS_DATA}, {6'h00, ans});
    repeat (4) @(posedge clk);
    rchk(UIVC_FIFO_STATUS_ADDR, 8'h00, "toggle_back");
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    $display("test receiver done");
    // Mailbox valid: plain bit, cleared on delivery
    // NAK flag of the empty token is still pending in bit 1
    wr(UIVC_USB_STATUS_ADDR, 8'h01);
    rchk(UIVC_USB_STATUS_ADDR, 8'h03, "mbox_set");
    wr(UIVC_USB_STATUS_ADDR, 8'h00);
    rchk(UIVC_USB_STATUS_ADDR, 8'h02, "mbox_clear");
    wr(UIVC_USB_STATUS_ADDR, 8'h01);
    rchk(UIVC_USB_STATUS_ADDR, 8'h03, "rmw_read");
    // Write back what was read: clears NAK, keeps mailbox valid
    wr(UIVC_USB_STATUS_ADDR, 8'h03);
    rchk(UIVC_USB_STATUS_ADDR, 8'h01, "mbox_only_rw");
    wr(UIVC_INT_MASK_ADDR, 8'h04);
    i_uivc_host_model.mbox_in();
    chk("mbox_pulses", 8'h01, 8'(i_uivc_host_model.mbox_seen));
    rchk(UIVC_USB_STATUS_ADDR, 8'h00, "mbox_auto_clear");
    rchk(UIVC_INT_STATUS_ADDR, 8'h04, "mbox_sent_status");
    chk("mbox_irq", 8'h01, {7'h00, irq});
    wr(UIVC_USB_STATUS_ADDR, 8'h00);
    wr(UIVC_INT_STATUS_ADDR, 8'h04);
    rchk(UIVC_INT_STATUS_ADDR, 8'h00, "mbox_status_clear");
    chk("mbox_irq_off", 8'h00, {7'h00, irq});
    $display("test mailbox done");
    // Valid set one cycle before the token, defect on then off
    i_uivc_host_model.ack_delay = 1;
    zlp_en <= 1'b1;
    fork
      wr(UIVC_FIFO_STATUS_ADDR, 8'h20);
      begin
        @(posedge clk);
        i_uivc_host_model.bulk_in(ans);
      end
    join
    chk("late_zlp", {6'h00, UIVC_ANS_ZLP}, {6'h00, ans});
    repeat (4) @(posedge clk);
    wr(UIVC_FIFO_STATUS_ADDR, 8'h00);
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    zlp_en <= 1'b0;
    fork
      wr(UIVC_FIFO_STATUS_ADDR, 8'h20);
      begin
        @(posedge clk);
        i_uivc_host_model.bulk_in(ans);
      end
    join
    chk("late_nak", {6'h00, UIVC_ANS_NAK}, {6'h00, ans});
    $display("test late valid done");
    // Poll for a NAK, then set valid well before the next token
    wr(UIVC_FIFO_STATUS_ADDR, 8'h00);
    wr(UIVC_INT_STATUS_ADDR, 8'h10);
    i_uivc_host_model.bulk_in(ans);
    chk("poll_nak", {6'h00, UIVC_ANS_NAK}, {6'h00, ans});
    rchk(UIVC_INT_STATUS_ADDR, 8'h10, "poll_status");
    wr(UIVC_FIFO_STATUS_ADDR, 8'h20);
    repeat (4) @(posedge clk);
    i_uivc_host_model.bulk_in(ans);
    chk("poll_data", {6'h00, UIVC_ANS_DATA}, {6'h00, ans});
    $display("test poll done");
    wrap_up();
  end
endmodule
